//--- rtl/dlc_pkg.sv
// Package: register map, field layouts and reset values for the DAC load/clear/limit block
package dlc_pkg;
    localparam int DLC_NUM_DAC = 12;
    localparam int DLC_NUM_AUX = 4;
    localparam int DLC_DW = 12;
    localparam int DLC_CLR_LSB = 3;
    // Register indices; byte address is index times four
    localparam logic [7:0] DLC_IDX_HW_CLR_MASK1 = 8'h57;
    localparam logic [7:0] DLC_IDX_LOAD_CFG = 8'h58;
    localparam logic [7:0] DLC_IDX_RANGE_SEL = 8'h59;
    localparam logic [7:0] DLC_IDX_AUX_LIMIT_BASE = 8'h5A;
    localparam logic [7:0] DLC_IDX_LT_UPPER = 8'h62;
    localparam logic [7:0] DLC_IDX_LT_LOWER = 8'h63;
    localparam logic [7:0] DLC_IDX_SW_CLEAR = 8'h55;
    localparam logic [7:0] DLC_IDX_DEV_CTRL = 8'h70;
    localparam logic [7:0] DLC_IDX_IRQ_STATUS = 8'h71;
    localparam logic [7:0] DLC_IDX_IRQ_MASK = 8'h72;
    localparam logic [7:0] DLC_IDX_DAC_DATA_BASE = 8'h80;
    localparam logic [7:0] DLC_IDX_DAC_OUT_BASE = 8'h90;
    localparam logic [7:0] DLC_IDX_DIFF_MODE = 8'h73;
    localparam logic [7:0] DLC_IDX_AUX_DATA_BASE = 8'h74;
    localparam logic [7:0] DLC_IDX_ALARM_CLR_EN = 8'h78;
    localparam int DLC_LOAD_BIT = 0;
    localparam logic [15:0] DLC_RST_ZERO = 16'h0000;
    localparam logic [11:0] DLC_RST_LT_UPPER = 12'h7FF;
    localparam logic [11:0] DLC_RST_LT_LOWER = 12'h800;
    localparam logic [11:0] DLC_RST_AUX_UPPER = 12'hFFF;
    localparam logic [11:0] DLC_RST_AUX_LOWER = 12'h000;
    localparam logic [1:0] DLC_RESP_OKAY = 2'b00;
    localparam logic [1:0] DLC_RESP_SLVERR = 2'b10;
endpackage : dlc_pkg

//--- rtl/dlc_regs.sv
// DAC load, clear and alarm-window register bank behind an AXI4-Lite slave
// Operation
// - Pin-one clear mask bit set forces that DAC clear while clear_pin_one_n is low.
// - Sync-load bit 0: data write updates latch immediately; load pulse ignored.
// - Sync-load bit 1: data write updates register only; load pulse copies to latch.
// - Writing one to load bit in device control register makes internal load pulse.
// - Untouched channels are not reloaded; latch updates reach output at once.
// - Non-auto DAC mode ignores sync-load bit and always loads asynchronously.
// - Pin, alarm or software clear forces DACs clear regardless of sync-load.
// - Range bit 1 selects gain five, 0 selects gain two.
// - Aux inputs and the local temperature sensor each have upper and lower limit registers.
// - Aux result outside its window sets its out-of-range flag.
// - Single-ended compares unsigned; differential pairs signed using channel 0 and 2 limits.
// - Upper four bits of limit registers read zero and ignore writes.
// - Local temperature upper limit resets to 07FFh.
// - Software clear bit one forces DAC clear; zero restores operation.
`timescale 1ns/1ps
`default_nettype none
module dlc_regs
    import dlc_pkg::*;
#(
    parameter int NUM_DAC = DLC_NUM_DAC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clear_pin_one_n,
    input wire logic [NUM_DAC-1:0] alarm_clear_req,
    input wire logic [2*NUM_DAC-1:0] dac_mode,
    input wire logic [DLC_NUM_AUX*DLC_DW-1:0] aux_result,
    input wire logic [DLC_NUM_AUX-1:0] aux_result_valid,
    output logic [NUM_DAC*DLC_DW-1:0] dac_out,
    output logic [NUM_DAC-1:0] dac_clear,
    output logic [NUM_DAC-1:0] range_select_bit,
    output logic [DLC_NUM_AUX-1:0] aux_out_of_range_flag,
    output logic irq
);
    logic aw_held, w_held;
    logic [7:0] aw_idx;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [15:0] hw_clear_mask_pin1, dac_load_config, dac_range_select, software_clear_reg;
    logic [3:0] diff_mode, alarm_clr_en;
    logic [11:0] local_temp_upper_limit, local_temp_lower_limit;
    logic [11:0] aux_input_upper_limit [DLC_NUM_AUX];
    logic [11:0] aux_input_lower_limit [DLC_NUM_AUX];
    logic [11:0] dac_data [NUM_DAC];
    logic [11:0] dac_latch [NUM_DAC];
    logic [DLC_NUM_AUX-1:0] irq_status, irq_mask;
    logic [DLC_NUM_AUX-1:0] window_bad;
    logic [NUM_DAC-1:0] clear_now;
    logic internal_load_pulse;

    logic next_aw_held, next_w_held, next_bvalid, next_rvalid, next_irq;
    logic next_awready, next_wready, next_arready;
    logic [7:0] next_aw_idx;
    logic [31:0] next_wdata_q, next_rdata;
    logic [3:0] next_wstrb_q;
    logic [1:0] next_bresp, next_rresp;
    logic [15:0] next_hw_clear_mask_pin1, next_dac_load_config, next_dac_range_select;
    logic [15:0] next_software_clear_reg;
    logic [3:0] next_diff_mode, next_alarm_clr_en;
    logic [11:0] next_lt_upper, next_lt_lower;
    logic [11:0] next_aux_upper [DLC_NUM_AUX];
    logic [11:0] next_aux_lower [DLC_NUM_AUX];
    logic [11:0] next_dac_data [NUM_DAC];
    logic [11:0] next_dac_latch [NUM_DAC];
    logic [DLC_NUM_AUX-1:0] next_irq_status, next_irq_mask, next_flag;
    logic [NUM_DAC-1:0] next_dac_clear;
    logic [NUM_DAC*DLC_DW-1:0] next_dac_out;
    logic do_write, do_read, wr_hit;
    logic [11:0] wr12;

    // Window comparison per aux input; differential pairs use the even channel limits
    always_comb begin
        for (int i = 0; i < DLC_NUM_AUX; i++) begin
            int lim;
            logic pair;
            logic [11:0] v;
            lim = i;
            pair = diff_mode[i & 2];
            v = aux_result[i*DLC_DW +: DLC_DW];
            if (pair) begin
                lim = i & 2;
            end
            if (pair) begin
                window_bad[i] = ($signed(v) > $signed(aux_input_upper_limit[lim])) ||
                                ($signed(v) < $signed(aux_input_lower_limit[lim]));
            end else begin
                window_bad[i] = (v > aux_input_upper_limit[lim]) ||
                                (v < aux_input_lower_limit[lim]);
            end
            // Upper not above lower keeps the alarm asserted
            if (pair ? ($signed(aux_input_upper_limit[lim]) <= $signed(aux_input_lower_limit[lim]))
                     : (aux_input_upper_limit[lim] <= aux_input_lower_limit[lim])) begin
                window_bad[i] = 1'b1;
            end
        end
    end

    always_comb begin
        do_write = aw_held && w_held && !s_axi_bvalid;
        do_read = s_axi_arvalid && s_axi_arready;
        wr12 = wdata_q[11:0];
        internal_load_pulse = do_write && aw_idx == DLC_IDX_DEV_CTRL && wstrb_q[0] &&
                              wdata_q[DLC_LOAD_BIT];
        for (int c = 0; c < NUM_DAC; c++) begin
            clear_now[c] = (hw_clear_mask_pin1[c+DLC_CLR_LSB] && !clear_pin_one_n) ||
                           software_clear_reg[c+DLC_CLR_LSB] ||
                           alarm_clear_req[c] ||
                           (alarm_clr_en[0] && (|(irq_status & window_bad)));
        end
    end

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_idx = aw_idx;
        next_wdata_q = wdata_q;
        next_wstrb_q = wstrb_q;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_hw_clear_mask_pin1 = hw_clear_mask_pin1;
        next_dac_load_config = dac_load_config;
        next_dac_range_select = dac_range_select;
        next_software_clear_reg = software_clear_reg;
        next_diff_mode = diff_mode;
        next_alarm_clr_en = alarm_clr_en;
        next_lt_upper = local_temp_upper_limit;
        next_lt_lower = local_temp_lower_limit;
        next_aux_upper = aux_input_upper_limit;
        next_aux_lower = aux_input_lower_limit;
        next_dac_data = dac_data;
        next_dac_latch = dac_latch;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        wr_hit = 1'b1;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_idx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_wdata_q = s_axi_wdata;
            next_wstrb_q = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            if (wstrb_q[1:0] == 2'b11) begin
                unique case (aw_idx)
                    DLC_IDX_HW_CLR_MASK1: next_hw_clear_mask_pin1 = {1'b0, wdata_q[14:3], 3'h0};
                    DLC_IDX_LOAD_CFG: next_dac_load_config = {4'h0, wr12};
                    DLC_IDX_RANGE_SEL: next_dac_range_select = {4'h0, wr12};
                    DLC_IDX_SW_CLEAR: next_software_clear_reg = {1'b0, wdata_q[14:3], 3'h0};
                    DLC_IDX_LT_UPPER: next_lt_upper = wr12;
                    DLC_IDX_LT_LOWER: next_lt_lower = wr12;
                    DLC_IDX_DEV_CTRL: ;
                    DLC_IDX_IRQ_STATUS: next_irq_status = irq_status & ~wdata_q[3:0];
                    DLC_IDX_IRQ_MASK: next_irq_mask = wdata_q[3:0];
                    DLC_IDX_DIFF_MODE: next_diff_mode = wdata_q[3:0];
                    DLC_IDX_ALARM_CLR_EN: next_alarm_clr_en = wdata_q[3:0];
                    default: begin
                        if (aw_idx >= DLC_IDX_AUX_LIMIT_BASE && aw_idx < DLC_IDX_AUX_LIMIT_BASE + 8'h08) begin
                            if (aw_idx[0] == DLC_IDX_AUX_LIMIT_BASE[0]) begin
                                next_aux_upper[2'((aw_idx - DLC_IDX_AUX_LIMIT_BASE) >> 1)] = wr12;
                            end else begin
                                next_aux_lower[2'((aw_idx - DLC_IDX_AUX_LIMIT_BASE) >> 1)] = wr12;
                            end
                        end else if (aw_idx >= DLC_IDX_DAC_DATA_BASE &&
                                     aw_idx < DLC_IDX_DAC_DATA_BASE + 8'(NUM_DAC)) begin
                            next_dac_data[4'(aw_idx - DLC_IDX_DAC_DATA_BASE)] = wr12;
                            // Immediate load unless sync-load in auto mode
                            if (!dac_load_config[4'(aw_idx - DLC_IDX_DAC_DATA_BASE)] ||
                                dac_mode[2*(4'(aw_idx - DLC_IDX_DAC_DATA_BASE)) +: 2] != 2'b00) begin
                                next_dac_latch[4'(aw_idx - DLC_IDX_DAC_DATA_BASE)] = wr12;
                            end
                        end else begin
                            wr_hit = 1'b0;
                        end
                    end
                endcase
            end
            next_bresp = wr_hit ? DLC_RESP_OKAY : DLC_RESP_SLVERR;
        end
        if (internal_load_pulse) begin
            for (int c = 0; c < NUM_DAC; c++) begin
                if (dac_load_config[c] && dac_mode[2*c +: 2] == 2'b00) begin
                    next_dac_latch[c] = dac_data[c];
                end
            end
        end
        // Set wins over clear
        next_irq_status = next_irq_status | (window_bad & aux_result_valid);
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp = DLC_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (s_axi_araddr[9:2])
                DLC_IDX_HW_CLR_MASK1: next_rdata[15:0] = hw_clear_mask_pin1;
                DLC_IDX_LOAD_CFG: next_rdata[15:0] = dac_load_config;
                DLC_IDX_RANGE_SEL: next_rdata[15:0] = dac_range_select;
                DLC_IDX_SW_CLEAR: next_rdata[15:0] = software_clear_reg;
                DLC_IDX_LT_UPPER: next_rdata[11:0] = local_temp_upper_limit;
                DLC_IDX_LT_LOWER: next_rdata[11:0] = local_temp_lower_limit;
                DLC_IDX_DEV_CTRL: next_rdata = 32'h0000_0000;
                DLC_IDX_IRQ_STATUS: next_rdata[3:0] = irq_status;
                DLC_IDX_IRQ_MASK: next_rdata[3:0] = irq_mask;
                DLC_IDX_DIFF_MODE: next_rdata[3:0] = diff_mode;
                DLC_IDX_ALARM_CLR_EN: next_rdata[3:0] = alarm_clr_en;
                default: begin
                    if (s_axi_araddr[9:2] >= DLC_IDX_AUX_LIMIT_BASE &&
                        s_axi_araddr[9:2] < DLC_IDX_AUX_LIMIT_BASE + 8'h08) begin
                        if (s_axi_araddr[2] == DLC_IDX_AUX_LIMIT_BASE[0]) begin
                            next_rdata[11:0] = aux_input_upper_limit[2'((s_axi_araddr[9:2] - DLC_IDX_AUX_LIMIT_BASE) >> 1)];
                        end else begin
                            next_rdata[11:0] = aux_input_lower_limit[2'((s_axi_araddr[9:2] - DLC_IDX_AUX_LIMIT_BASE) >> 1)];
                        end
                    end else if (s_axi_araddr[9:2] >= DLC_IDX_DAC_DATA_BASE &&
                                 s_axi_araddr[9:2] < DLC_IDX_DAC_DATA_BASE + 8'(NUM_DAC)) begin
                        next_rdata[11:0] = dac_data[4'(s_axi_araddr[9:2] - DLC_IDX_DAC_DATA_BASE)];
                    end else if (s_axi_araddr[9:2] >= DLC_IDX_DAC_OUT_BASE &&
                                 s_axi_araddr[9:2] < DLC_IDX_DAC_OUT_BASE + 8'(NUM_DAC)) begin
                        next_rdata[11:0] = dac_latch[4'(s_axi_araddr[9:2] - DLC_IDX_DAC_OUT_BASE)];
                    end else begin
                        next_rresp = DLC_RESP_SLVERR;
                    end
                end
            endcase
        end
        for (int c = 0; c < NUM_DAC; c++) begin
            next_dac_clear[c] = clear_now[c];
            next_dac_out[c*DLC_DW +: DLC_DW] = clear_now[c] ? 12'h000 : next_dac_latch[c];
        end
        next_flag = next_irq_status;
        next_irq = |(next_irq_status & next_irq_mask);
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DLC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= DLC_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
            hw_clear_mask_pin1 <= DLC_RST_ZERO;
            dac_load_config <= DLC_RST_ZERO;
            dac_range_select <= DLC_RST_ZERO;
            software_clear_reg <= DLC_RST_ZERO;
            diff_mode <= 4'h0;
            alarm_clr_en <= 4'h0;
            local_temp_upper_limit <= DLC_RST_LT_UPPER;
            local_temp_lower_limit <= DLC_RST_LT_LOWER;
            for (int i = 0; i < DLC_NUM_AUX; i++) begin
                aux_input_upper_limit[i] <= DLC_RST_AUX_UPPER;
                aux_input_lower_limit[i] <= DLC_RST_AUX_LOWER;
            end
            for (int c = 0; c < NUM_DAC; c++) begin
                dac_data[c] <= 12'h000;
                dac_latch[c] <= 12'h000;
            end
            irq_status <= 4'h0;
            irq_mask <= 4'h0;
            aux_out_of_range_flag <= 4'h0;
            dac_clear <= '0;
            dac_out <= '0;
            irq <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_idx <= next_aw_idx;
            wdata_q <= next_wdata_q;
            wstrb_q <= next_wstrb_q;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            hw_clear_mask_pin1 <= next_hw_clear_mask_pin1;
            dac_load_config <= next_dac_load_config;
            dac_range_select <= next_dac_range_select;
            software_clear_reg <= next_software_clear_reg;
            diff_mode <= next_diff_mode;
            alarm_clr_en <= next_alarm_clr_en;
            local_temp_upper_limit <= next_lt_upper;
            local_temp_lower_limit <= next_lt_lower;
            aux_input_upper_limit <= next_aux_upper;
            aux_input_lower_limit <= next_aux_lower;
            dac_data <= next_dac_data;
            dac_latch <= next_dac_latch;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            aux_out_of_range_flag <= next_flag;
            dac_clear <= next_dac_clear;
            dac_out <= next_dac_out;
            irq <= next_irq;
        end
    end

    always_comb begin
        range_select_bit = dac_range_select[NUM_DAC-1:0];
    end

    a_pin_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (!clear_pin_one_n && hw_clear_mask_pin1[DLC_CLR_LSB]) |=> dac_clear[0])
        else $error("pin clear not applied");
    a_sw_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        software_clear_reg[DLC_CLR_LSB] |=> (dac_clear[0] && dac_out[11:0] == 12'h000))
        else $error("software clear not applied");
    a_sync_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (!internal_load_pulse && dac_load_config[1] && dac_mode[3:2] == 2'b00)
        |=> dac_latch[1] == $past(dac_latch[1]))
        else $error("sync latch changed without load");
    a_load_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        (internal_load_pulse && dac_load_config[1] && dac_mode[3:2] == 2'b00)
        |=> dac_latch[1] == $past(dac_data[1]))
        else $error("load pulse did not copy");
    a_out_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        !clear_now[0] |=> dac_out[11:0] == dac_latch[0])
        else $error("output not following latch");
    a_lt_reset: assert property (@(posedge aclk)
        !aresetn |=> local_temp_upper_limit == 12'h7FF)
        else $error("local upper limit reset wrong");
    a_bad_window: assert property (@(posedge aclk) disable iff (!aresetn)
        (aux_result_valid[0] && window_bad[0]) |=> aux_out_of_range_flag[0])
        else $error("alarm flag not set");
    a_range_map: assert property (@(posedge aclk) disable iff (!aresetn)
        range_select_bit == dac_range_select[NUM_DAC-1:0] && dac_range_select[15:12] == 4'h0)
        else $error("range select mismatch");
endmodule : dlc_regs
`default_nettype wire

//--- tb/dlc_host.sv
// Host model: AXI4-Lite master that reaches the register bank
`timescale 1ns/1ps
`default_nettype none
module dlc_host (
    input wire logic aclk,
    output logic [9:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [9:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    int stuck = 0;
    initial begin
        s_axi_awaddr = 10'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = 10'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
    end
    task automatic wr(input logic [7:0] idx, input logic [15:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end while (!s_axi_bvalid && n < 50);
        resp = s_axi_bresp;
        if (n >= 50) stuck++;
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        if (n >= 50) stuck++;
    endtask : rd
endmodule : dlc_host
`default_nettype wire

//--- tb/dlc_regs_tb_top.sv
// Testbench top: register bank driven by the host model
`timescale 1ns/1ps
`default_nettype none
module dlc_regs_tb_top
    import dlc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clear_pin_one_n = 1'b1;
    logic [11:0] alarm_clear_req = 12'h000;
    logic [23:0] dac_mode = 24'h000000;
    logic [47:0] aux_result = 48'h0;
    logic [3:0] aux_result_valid = 4'h0;
    logic [143:0] dac_out;
    logic [11:0] dac_clear, range_select_bit;
    logic [3:0] aux_out_of_range_flag;
    logic irq;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fail_count = 0;
    int total_checks = 0;
    always #20 aclk = ~aclk;
    dlc_host u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    dlc_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .clear_pin_one_n, .alarm_clear_req, .dac_mode,
        .aux_result, .aux_result_valid, .dac_out, .dac_clear, .range_select_bit,
        .aux_out_of_range_flag, .irq);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic bus_ok();
        if (u_host.stuck != 0) begin
            fail_count++;
            conclude();
        end
    endtask : bus_ok
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [1:0] r;
        u_host.wr(idx, d, r);
        bus_ok();
        chk("bresp", 32'(r), 32'(DLC_RESP_OKAY));
    endtask : wr
    task automatic rc(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        u_host.rd(idx, d, r);
        bus_ok();
        chk("rresp", 32'(r), 32'(er));
        chk("rdata", d, exp);
    endtask : rc
    task automatic dchk(input int c, input logic [11:0] exp);
        chk("dac_out", 32'(dac_out[c*12 +: 12]), 32'(exp));
    endtask : dchk
    task automatic aux(input int ch, input logic [11:0] v);
        aux_result[ch*12 +: 12] <= v;
        aux_result_valid <= 4'(1 << ch);
        tick(1);
        aux_result_valid <= 4'h0;
        tick(3);
    endtask : aux
    task automatic t_reset();
        chk("dac_clear", 32'(dac_clear), 32'h0);
        rc(DLC_IDX_HW_CLR_MASK1, 32'h0, DLC_RESP_OKAY);
        rc(DLC_IDX_LOAD_CFG, 32'h0, DLC_RESP_OKAY);
        rc(DLC_IDX_RANGE_SEL, 32'h0, DLC_RESP_OKAY);
        rc(DLC_IDX_LT_UPPER, 32'h07FF, DLC_RESP_OKAY);
        rc(DLC_IDX_AUX_LIMIT_BASE, 32'h0FFF, DLC_RESP_OKAY);
        rc(DLC_IDX_AUX_LIMIT_BASE + 8'h01, 32'h0, DLC_RESP_OKAY);
        rc(8'h40, 32'h0, DLC_RESP_SLVERR);
    endtask : t_reset
    task automatic t_limits();
        for (int i = 0; i < 8; i++) begin
            wr(DLC_IDX_AUX_LIMIT_BASE + 8'(i), 16'hF000 | 16'(i));
            rc(DLC_IDX_AUX_LIMIT_BASE + 8'(i), 32'(i), DLC_RESP_OKAY);
        end
        wr(DLC_IDX_LT_UPPER, 16'hA123);
        rc(DLC_IDX_LT_UPPER, 32'h0123, DLC_RESP_OKAY);
    endtask : t_limits
    task automatic t_load();
        wr(DLC_IDX_DAC_DATA_BASE, 16'h05A5);
        tick(2);
        dchk(0, 12'h5A5);
        dchk(1, 12'h000);
        wr(DLC_IDX_LOAD_CFG, 16'h0002);
        wr(DLC_IDX_DAC_DATA_BASE + 8'h01, 16'h0321);
        tick(2);
        dchk(1, 12'h000);
        rc(DLC_IDX_DAC_OUT_BASE + 8'h01, 32'h0, DLC_RESP_OKAY);
        rc(DLC_IDX_DAC_DATA_BASE + 8'h01, 32'h0321, DLC_RESP_OKAY);
        wr(DLC_IDX_DEV_CTRL, 16'h0001);
        tick(2);
        dchk(1, 12'h321);
        dchk(0, 12'h5A5);
        dac_mode[3:2] <= 2'b01;
        wr(DLC_IDX_DAC_DATA_BASE + 8'h01, 16'h0777);
        tick(2);
        dchk(1, 12'h777);
    endtask : t_load
    task automatic t_clear();
        wr(DLC_IDX_HW_CLR_MASK1, 16'h0008);
        clear_pin_one_n <= 1'b0;
        tick(3);
        chk("dac_clear", 32'(dac_clear), 32'h001);
        dchk(0, 12'h000);
        dchk(1, 12'h777);
        wr(DLC_IDX_SW_CLEAR, 16'h0008);
        clear_pin_one_n <= 1'b1;
        tick(3);
        dchk(0, 12'h000);
        wr(DLC_IDX_SW_CLEAR, 16'h0010);
        tick(3);
        chk("dac_clear", 32'(dac_clear), 32'h002);
        dchk(0, 12'h5A5);
        wr(DLC_IDX_SW_CLEAR, 16'h0000);
        alarm_clear_req <= 12'h004;
        tick(3);
        chk("dac_clear", 32'(dac_clear), 32'h004);
        dchk(1, 12'h777);
        alarm_clear_req <= 12'h000;
        tick(3);
        chk("dac_clear", 32'(dac_clear), 32'h000);
    endtask : t_clear
    task automatic t_alarm();
        wr(DLC_IDX_RANGE_SEL, 16'hF0A5);
        tick(2);
        chk("range", 32'(range_select_bit), 32'h0A5);
        wr(DLC_IDX_IRQ_MASK, 16'h000F);
        wr(DLC_IDX_AUX_LIMIT_BASE, 16'h0800);
        wr(DLC_IDX_AUX_LIMIT_BASE + 8'h01, 16'h0100);
        aux(0, 12'h900);
        chk("flag", 32'(aux_out_of_range_flag), 32'h1);
        chk("irq", 32'(irq), 32'h1);
        wr(DLC_IDX_IRQ_STATUS, 16'h0001);
        aux(0, 12'h500);
        chk("flag", 32'(aux_out_of_range_flag), 32'h0);
        chk("irq", 32'(irq), 32'h0);
        wr(DLC_IDX_IRQ_MASK, 16'h0000);
        wr(DLC_IDX_DIFF_MODE, 16'h0001);
        wr(DLC_IDX_AUX_LIMIT_BASE, 16'h0100);
        wr(DLC_IDX_AUX_LIMIT_BASE + 8'h01, 16'h0F00);
        aux(0, 12'hF80);
        chk("flag", 32'(aux_out_of_range_flag), 32'h0);
        wr(DLC_IDX_AUX_LIMIT_BASE + 8'h06, 16'h0100);
        wr(DLC_IDX_AUX_LIMIT_BASE + 8'h07, 16'h0200);
        aux(3, 12'h180);
        chk("flag", 32'(aux_out_of_range_flag), 32'h8);
        chk("irq", 32'(irq), 32'h0);
        wr(DLC_IDX_ALARM_CLR_EN, 16'h0001);
        tick(2);
        chk("dac_clear", 32'(dac_clear), 32'hFFF);
        wr(DLC_IDX_ALARM_CLR_EN, 16'h0000);
        tick(2);
        chk("dac_clear", 32'(dac_clear), 32'h000);
    endtask : t_alarm
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_limits();
        t_load();
        t_clear();
        t_alarm();
        conclude();
    end
endmodule : dlc_regs_tb_top
`default_nettype wire
